// [logic/trig_pkg.sv]
package trig_pkg;
  // line index map of the crosspoint
  localparam int N_TTL = 8;
  localparam int N_ECL = 6;
  localparam int N_STAR = 13;
  localparam int N_EXT = 10;
  localparam int N_LINES = 64;
  localparam logic [5:0] TTL_BASE = 6'h00;
  localparam logic [5:0] ECL_BASE = 6'h08;
  localparam logic [5:0] STARX_BASE = 6'h0E;
  localparam logic [5:0] STARY_BASE = 6'h1B;
  localparam logic [5:0] EXT_BASE = 6'h28;
  localparam logic [5:0] CNT_PULSE_LINE = 6'h32;
  localparam logic [5:0] CNT_DONE_LINE = 6'h33;
  localparam logic [5:0] PRIMARY_TICK_OUTPUT_LINE = 6'h3C;
  localparam logic [5:0] SECONDARY_TICK_OUTPUT_LINE = 6'h3D;
  localparam logic [5:0] CLK10_LINE = 6'h3E;
  localparam logic [5:0] EXTERNAL_CONDITIONING_CLOCK_LINE = 6'h3F;
  localparam int N_TRIG = N_TTL + N_ECL;
  localparam int EXT_CLK_GPIO = 3;
  // conditioning bit positions
  localparam int COND_SYNC = 0;
  localparam int COND_INV = 1;
  localparam int COND_STRETCH = 2;
  localparam int COND_EXTERNAL_CONDITIONING_CLOCK = 3;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [4:0] TICK_RESET = 5'h00;

  typedef enum logic [1:0] {
    CNT_OP_NONE,
    CNT_OP_INIT,
    CNT_OP_RELOAD,
    CNT_OP_DISABLE
  } cnt_op_t;

  typedef enum logic [2:0] {
    TICK_OP_NONE,
    TICK_OP_INIT_AUTO,
    TICK_OP_INIT_MANUAL,
    TICK_OP_RELOAD,
    TICK_OP_DISABLE
  } tick_op_t;

  typedef struct packed {
    logic connect;
    logic disconnect;
    logic [5:0] src;
    logic [5:0] dst;
    logic [3:0] cond;
  } route_cmd_t;

  typedef struct packed {
    logic valid;
    logic [5:0] src;
    logic [3:0] cond;
  } route_entry_t;

  typedef struct packed {
    logic write;
    logic [3:0] line;
    logic sync;
    logic ext_semi;
  } gen_setup_t;

  typedef struct packed {
    logic write;
    logic [3:0] line;
    logic feedback;
    logic invert;
    logic force_en;
    logic force_level;
  } ext_setup_t;
endpackage

// [logic/route_table.sv]
`timescale 1ns/1ps
// destination-indexed route memory, registered read port
module route_table (
  input wire logic clock,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire trig_pkg::route_entry_t wr_data,
  // all entries, registered
  output trig_pkg::route_entry_t entries [trig_pkg::N_LINES]
);
  trig_pkg::route_entry_t mem [trig_pkg::N_LINES];

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < trig_pkg::N_LINES; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < trig_pkg::N_LINES; i++) begin
        entries[i] <= '0;
      end
    end else begin
      entries <= mem;
    end
  end
endmodule // route_table

// [logic/trigger_router.sv]
`timescale 1ns/1ps
module trigger_router (
  input wire logic clock,
  input wire logic rst,
  // backplane and front-panel lines, sampled
  input wire logic clk10_in,
  input wire logic [trig_pkg::N_TTL-1:0] ttl_in,
  input wire logic [trig_pkg::N_ECL-1:0] ecl_in,
  input wire logic [trig_pkg::N_STAR-1:0] starx_in,
  input wire logic [trig_pkg::N_STAR-1:0] stary_in,
  input wire logic [trig_pkg::N_EXT-1:0] ext_in,
  // driven lines
  output logic [trig_pkg::N_TTL-1:0] ttl_out,
  output logic [trig_pkg::N_TTL-1:0] ttl_oe,
  output logic [trig_pkg::N_ECL-1:0] ecl_out,
  output logic [trig_pkg::N_ECL-1:0] ecl_oe,
  output logic [trig_pkg::N_STAR-1:0] starx_out,
  output logic [trig_pkg::N_STAR-1:0] starx_oe,
  output logic [trig_pkg::N_STAR-1:0] stary_out,
  output logic [trig_pkg::N_STAR-1:0] stary_oe,
  output logic [trig_pkg::N_EXT-1:0] ext_out,
  output logic [trig_pkg::N_EXT-1:0] ext_oe,
  // routing
  input wire trig_pkg::route_cmd_t route_cmd,
  output logic route_refused,
  // generation and external setup
  input wire trig_pkg::gen_setup_t trigger_generation_setup,
  input wire logic sync_falling_edge,
  input wire trig_pkg::ext_setup_t external_line_setup,
  // sense and acknowledge, index 0..13 trigger lines
  input wire logic [trig_pkg::N_TRIG-1:0] sense_start_command,
  input wire logic [trig_pkg::N_TRIG-1:0] sense_stop_command,
  input wire logic [trig_pkg::N_TRIG-1:0] sense_ack_needed,
  input wire logic [trig_pkg::N_TRIG-1:0] acknowledge_command,
  output logic [trig_pkg::N_TRIG-1:0] trigger_sensed,
  output logic [trig_pkg::N_TRIG-1:0] ack_pending,
  output logic [trig_pkg::N_TRIG-1:0] ack_out,
  // counter
  input wire trig_pkg::cnt_op_t event_counter_setup,
  input wire logic [5:0] counter_source,
  input wire logic [15:0] counter_load,
  input wire logic counter_start,
  input wire logic counter_stop,
  output logic counter_step_pulse,
  output logic counter_done_level,
  output logic [15:0] counter_value,
  output logic counter_running,
  output logic counter_event,
  // tick timers
  input wire trig_pkg::tick_op_t tick_timer_setup,
  input wire logic [5:0] tick_source,
  input wire logic [4:0] tick_exp1,
  input wire logic [4:0] tick_exp2,
  input wire logic tick_start,
  input wire logic tick_stop,
  output logic primary_tick_output,
  output logic secondary_tick_output,
  output logic tick_running,
  output logic tick_event
);
  localparam int N_IN = 1 + trig_pkg::N_TTL + trig_pkg::N_ECL + 2 * trig_pkg::N_STAR;

  // pin synchroniser, change taken when stages 2 and 3 agree
  logic [N_IN-1:0] raw_in, s1, s2, s3, pin;
  assign raw_in = {clk10_in, ttl_in, ecl_in, starx_in, stary_in};
  // fed-back lines read a registered copy, so no route can close a loop
  logic [trig_pkg::N_EXT-1:0] e1, e2, e3, ext_pin, ext_fb;
  always_ff @(posedge clock) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin <= '0;
      e1 <= '0;
      e2 <= '0;
      e3 <= '0;
      ext_pin <= '0;
      ext_fb <= '0;
    end else begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
      pin <= (s2 & s3) | (pin & (s2 | s3));
      e1 <= ext_in;
      e2 <= e1;
      e3 <= e2;
      ext_pin <= (e2 & e3) | (ext_pin & (e2 | e3));
      ext_fb <= ext_out;
    end
  end
  logic clk10_s;
  assign clk10_s = pin[N_IN-1];

  // external line config
  logic [trig_pkg::N_EXT-1:0] ext_feedback, ext_inv, ext_force, ext_level;
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_feedback <= '0;
      ext_inv <= '0;
      ext_force <= '0;
      ext_level <= '0;
    end else if (external_line_setup.write && external_line_setup.line < 4'(trig_pkg::N_EXT)) begin
      ext_feedback[external_line_setup.line] <= external_line_setup.feedback;
      ext_inv[external_line_setup.line] <= external_line_setup.invert;
      ext_force[external_line_setup.line] <= external_line_setup.force_en;
      ext_level[external_line_setup.line] <= external_line_setup.force_level;
    end
  end

  logic [trig_pkg::N_EXT-1:0] ext_val;
  assign ext_val = ext_pin ^ ext_inv;
  // line 3 is the conditioning clock; fed-back lines read their own output
  logic external_conditioning_clock_s;
  assign external_conditioning_clock_s = ext_feedback[trig_pkg::EXT_CLK_GPIO] ? ext_fb[trig_pkg::EXT_CLK_GPIO]
                                                          : ext_val[trig_pkg::EXT_CLK_GPIO];

  // flat view of every line, by line index
  logic [trig_pkg::N_LINES-1:0] line_val;
  always_comb begin
    line_val = '0;
    line_val[7:0] = pin[N_IN-2 -: trig_pkg::N_TTL];
    line_val[13:8] = pin[N_IN-10 -: trig_pkg::N_ECL];
    line_val[26:14] = pin[N_IN-16 -: trig_pkg::N_STAR];
    line_val[39:27] = pin[N_IN-29 -: trig_pkg::N_STAR];
    for (int i = 0; i < trig_pkg::N_EXT; i++) begin
      line_val[40 + i] = ext_feedback[i] ? ext_fb[i] : ext_val[i];
    end
    line_val[trig_pkg::CNT_PULSE_LINE] = counter_step_pulse;
    line_val[trig_pkg::CNT_DONE_LINE] = counter_done_level;
    line_val[trig_pkg::PRIMARY_TICK_OUTPUT_LINE] = primary_tick_output;
    line_val[trig_pkg::SECONDARY_TICK_OUTPUT_LINE] = secondary_tick_output;
    line_val[trig_pkg::CLK10_LINE] = clk10_s;
    line_val[trig_pkg::EXTERNAL_CONDITIONING_CLOCK_LINE] = external_conditioning_clock_s;
  end

  // edges of the conditioning clocks
  logic clk10_d, external_conditioning_clock_d;
  always_ff @(posedge clock) begin
    if (rst) begin
      clk10_d <= 1'b0;
      external_conditioning_clock_d <= 1'b0;
    end else begin
      clk10_d <= clk10_s;
      external_conditioning_clock_d <= external_conditioning_clock_s;
    end
  end
  logic clk10_edge, external_conditioning_clock_edge;
  assign clk10_edge = sync_falling_edge ? (clk10_d & ~clk10_s) : (~clk10_d & clk10_s);
  assign external_conditioning_clock_edge = ~external_conditioning_clock_d & external_conditioning_clock_s;

  // route command checks
  logic dst_is_ext, dst_ok, src_ok;
  assign dst_is_ext = route_cmd.dst >= trig_pkg::EXT_BASE && route_cmd.dst < 6'h32;
  assign src_ok = !(route_cmd.src == trig_pkg::PRIMARY_TICK_OUTPUT_LINE && dst_is_ext)
               && !(route_cmd.src == trig_pkg::CNT_PULSE_LINE && dst_is_ext);
  assign dst_ok = route_cmd.dst < 6'h32
               && !(dst_is_ext && ext_force[4'(route_cmd.dst - trig_pkg::EXT_BASE)]);
  logic accept_connect;
  assign accept_connect = route_cmd.connect && src_ok && dst_ok;
  assign route_refused = route_cmd.connect && !accept_connect;

  trig_pkg::route_entry_t table_q [trig_pkg::N_LINES];
  trig_pkg::route_entry_t wr_entry;
  assign wr_entry = accept_connect
                    ? trig_pkg::route_entry_t'{1'b1, route_cmd.src, route_cmd.cond}
                    : '0;
  route_table u_table (
    .clock(clock),
    .rst(rst),
    .wr_en(accept_connect || (route_cmd.disconnect && table_q[route_cmd.dst].src == route_cmd.src)),
    .wr_addr(route_cmd.dst),
    .wr_data(wr_entry),
    .entries(table_q)
  );

  // per-destination conditioning
  logic [trig_pkg::N_LINES-1:0] routed, driven;
  logic [49:0] sync_q, stretch_q;
  genvar d;
  generate
    for (d = 0; d < 6'h32; d++) begin : g_dst
      logic raw, clk_edge, held;
      assign raw = line_val[table_q[d].src] ^ table_q[d].cond[trig_pkg::COND_INV];
      assign clk_edge = table_q[d].cond[trig_pkg::COND_EXTERNAL_CONDITIONING_CLOCK] ? external_conditioning_clock_edge : clk10_edge;
      always_ff @(posedge clock) begin
        if (rst) begin
          sync_q[d] <= 1'b0;
          stretch_q[d] <= 1'b0;
        end else begin
          if (clk_edge) begin
            sync_q[d] <= raw;
          end
          // holds a short pulse until the next clock edge has passed
          if (raw) begin
            stretch_q[d] <= 1'b1;
          end else if (clk_edge) begin
            stretch_q[d] <= 1'b0;
          end
        end
      end
      always_comb begin
        held = table_q[d].cond[trig_pkg::COND_SYNC] ? sync_q[d] : raw;
        if (table_q[d].cond[trig_pkg::COND_STRETCH]) begin
          held = held | stretch_q[d];
        end
      end
      assign routed[d] = held;
      assign driven[d] = table_q[d].valid;
    end
    for (d = 6'h32; d < trig_pkg::N_LINES; d++) begin : g_none
      assign routed[d] = 1'b0;
      assign driven[d] = 1'b0;
    end
  endgenerate

  // trigger generation and sensing per TTL/ECL line
  logic [trig_pkg::N_TRIG-1:0] gen_sync, gen_semi, sense_en, trig_prev, semi_hold, gen_q;
  logic [trig_pkg::N_TRIG-1:0] trig_now, trig_rise, ext_pulse;
  assign trig_now = line_val[13:0];
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_sync <= '0;
      gen_semi <= '0;
    end else if (trigger_generation_setup.write
                 && trigger_generation_setup.line < 4'(trig_pkg::N_TRIG)) begin
      gen_sync[trigger_generation_setup.line] <= trigger_generation_setup.sync;
      gen_semi[trigger_generation_setup.line] <= trigger_generation_setup.ext_semi;
    end
  end

  // an external line mapped onto a trigger line acknowledges it
  logic [trig_pkg::N_EXT-1:0] ext_prev;
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_prev <= '0;
    end else begin
      ext_prev <= ext_val;
    end
  end
  always_comb begin
    for (int t = 0; t < trig_pkg::N_TRIG; t++) begin
      ext_pulse[t] = 1'b0;
      for (int e = 0; e < trig_pkg::N_EXT; e++) begin
        if (table_q[t].valid && table_q[t].src == 6'(40 + e) && ext_prev[e] && !ext_val[e]) begin
          ext_pulse[t] = 1'b1;
        end
      end
    end
  end

  generate
    for (d = 0; d < trig_pkg::N_TRIG; d++) begin : g_trig
      always_ff @(posedge clock) begin
        if (rst) begin
          sense_en[d] <= 1'b0;
          trig_prev[d] <= 1'b0;
          trigger_sensed[d] <= 1'b0;
          ack_pending[d] <= 1'b0;
          ack_out[d] <= 1'b0;
          semi_hold[d] <= 1'b0;
          gen_q[d] <= 1'b0;
        end else begin
          trig_prev[d] <= trig_now[d];
          if (sense_start_command[d]) begin
            sense_en[d] <= 1'b1;
          end else if (sense_stop_command[d]) begin
            sense_en[d] <= 1'b0;
          end
          trigger_sensed[d] <= sense_en[d] && trig_rise[d];
          // new sense wins over a coincident acknowledge
          if (sense_en[d] && trig_rise[d] && sense_ack_needed[d]) begin
            ack_pending[d] <= 1'b1;
          end else if (acknowledge_command[d]) begin
            ack_pending[d] <= 1'b0;
          end
          ack_out[d] <= ack_pending[d] && acknowledge_command[d];
          if (gen_semi[d] && trig_rise[d]) begin
            semi_hold[d] <= 1'b1;
          end else if (ext_pulse[d] || acknowledge_command[d]) begin
            semi_hold[d] <= 1'b0;
          end
          if (clk10_edge) begin
            gen_q[d] <= routed[d];
          end
        end
      end
      assign trig_rise[d] = trig_now[d] && !trig_prev[d];
    end
  endgenerate

  // line drivers
  logic [trig_pkg::N_TRIG-1:0] gen_val;
  assign gen_val = (gen_sync & gen_q) | (~gen_sync & routed[13:0]);
  always_comb begin
    ttl_out = gen_val[7:0] | semi_hold[7:0];
    ttl_oe = driven[7:0] | semi_hold[7:0];
    ecl_out = gen_val[13:8] | semi_hold[13:8];
    ecl_oe = driven[13:8] | semi_hold[13:8];
    starx_out = routed[26:14];
    starx_oe = driven[26:14];
    stary_out = routed[39:27];
    stary_oe = driven[39:27];
    for (int e = 0; e < trig_pkg::N_EXT; e++) begin
      ext_out[e] = ext_force[e] ? ext_level[e] : routed[40 + e];
      ext_oe[e] = ext_force[e] | driven[40 + e];
    end
  end

  // counter and tick source edges
  logic cnt_src_d, tick_src_d, cnt_tick, tick_clk;
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_src_d <= 1'b0;
      tick_src_d <= 1'b0;
    end else begin
      cnt_src_d <= line_val[counter_source];
      tick_src_d <= line_val[tick_source];
    end
  end
  assign cnt_tick = line_val[counter_source] && !cnt_src_d;
  assign tick_clk = line_val[tick_source] && !tick_src_d;

  // event counter
  logic [7:0] pulse_cnt;
  always_ff @(posedge clock) begin
    if (rst) begin
      counter_value <= trig_pkg::CNT_RESET;
      counter_running <= 1'b0;
      counter_done_level <= 1'b0;
      counter_event <= 1'b0;
      pulse_cnt <= '0;
    end else begin
      counter_event <= 1'b0;
      case (event_counter_setup)
        trig_pkg::CNT_OP_INIT, trig_pkg::CNT_OP_RELOAD: begin
          if (counter_load != 16'h0000) begin
            counter_value <= counter_load;
            counter_running <= 1'b0;
          end
        end
        trig_pkg::CNT_OP_DISABLE: begin
          counter_running <= 1'b0;
          counter_done_level <= 1'b0;
        end
        default: begin
          if (counter_start && counter_value != 16'h0000) begin
            counter_running <= 1'b1;
          end else if (counter_stop) begin
            counter_running <= 1'b0;
          end else if (counter_running && cnt_tick) begin
            counter_value <= counter_value - 16'h0001;
            if (counter_value == 16'h0001) begin
              counter_done_level <= 1'b1;
              counter_running <= 1'b0;
              counter_event <= 1'b1;
            end
          end
        end
      endcase
      if (counter_running && cnt_tick) begin
        pulse_cnt <= 8'(trig_pkg::PULSE_CYC);
      end else if (pulse_cnt != 8'h00) begin
        pulse_cnt <= pulse_cnt - 8'h01;
      end
    end
  end
  assign counter_step_pulse = pulse_cnt != 8'h00;

  // tick timers share one counter
  logic [31:0] tick_cnt;
  logic tick_auto;
  logic [4:0] exp1, exp2;
  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt <= '0;
      tick_auto <= 1'b0;
      tick_running <= 1'b0;
      tick_event <= 1'b0;
      exp1 <= trig_pkg::TICK_RESET;
      exp2 <= trig_pkg::TICK_RESET;
    end else begin
      tick_event <= 1'b0;
      case (tick_timer_setup)
        trig_pkg::TICK_OP_INIT_AUTO, trig_pkg::TICK_OP_INIT_MANUAL: begin
          tick_auto <= tick_timer_setup == trig_pkg::TICK_OP_INIT_AUTO;
          exp1 <= tick_exp1;
          exp2 <= tick_exp2;
          tick_cnt <= '0;
          tick_running <= 1'b0;
        end
        trig_pkg::TICK_OP_RELOAD: begin
          tick_cnt <= '0;
        end
        trig_pkg::TICK_OP_DISABLE: begin
          tick_running <= 1'b0;
          tick_cnt <= '0;
        end
        default: begin
          if (tick_start) begin
            tick_running <= 1'b1;
          end else if (tick_stop) begin
            tick_running <= 1'b0;
          end else if (tick_running && tick_clk) begin
            tick_cnt <= tick_cnt + 32'h1;
            // first tick finishes a full period: low half ends
            if ((tick_cnt & ((32'h2 << exp1) - 32'h1)) == ((32'h2 << exp1) - 32'h1)) begin
              tick_event <= 1'b1;
              if (!tick_auto) begin
                tick_running <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // square waves: high for 2^n counts then low for 2^n
  always_ff @(posedge clock) begin
    if (rst) begin
      primary_tick_output <= 1'b0;
      secondary_tick_output <= 1'b0;
    end else begin
      primary_tick_output <= tick_running && !tick_cnt[exp1];
      secondary_tick_output <= tick_running && !tick_cnt[exp2];
    end
  end
endmodule // trigger_router

// [tb/trigger_router_sva.sv]
`timescale 1ns/1ps
module trigger_router_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // routing
  input wire trig_pkg::route_cmd_t route_cmd,
  input wire logic route_refused,
  // counter
  input wire trig_pkg::cnt_op_t event_counter_setup,
  input wire logic counter_start,
  input wire logic counter_step_pulse,
  input wire logic counter_done_level,
  input wire logic [15:0] counter_value,
  input wire logic counter_running,
  // acknowledge
  input wire logic [13:0] acknowledge_command,
  input wire logic [13:0] ack_pending,
  input wire logic [13:0] ack_out,
  // ticks
  input wire logic tick_start,
  input wire logic tick_running
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // counted, as 25 is too long a repetition to unroll
  logic [7:0] step_len;
  always_ff @(posedge clock) begin
    if (rst || !counter_step_pulse) begin
      step_len <= 8'h00;
    end else begin
      step_len <= step_len + 8'h01;
    end
  end
  sequence s_last_step;
    event_counter_setup == trig_pkg::CNT_OP_NONE && counter_value == 16'h0001
      ##1 counter_value == 16'h0000;
  endsequence
  property p_primary_tick_output_ext;
    route_cmd.connect && route_cmd.src == trig_pkg::PRIMARY_TICK_OUTPUT_LINE
      && route_cmd.dst[5:3] == 3'h5 |-> route_refused;
  endproperty
  property p_step_len;
    $fell(counter_step_pulse) |-> step_len == 8'(trig_pkg::PULSE_CYC);
  endproperty
  property p_done_rise;
    s_last_step |-> ##[0:1] counter_done_level;
  endproperty
  property p_done_hold;
    counter_done_level && event_counter_setup != trig_pkg::CNT_OP_DISABLE |=> counter_done_level;
  endproperty
  property p_cnt_start;
    $rose(counter_running) |-> $past(counter_start);
  endproperty
  property p_ack_cause;
    ack_out != 14'h0000 |-> (ack_out & ~$past(acknowledge_command)) == 14'h0000;
  endproperty
  property p_ack_clear;
    ack_pending[2] && acknowledge_command[2] |=> !ack_pending[2];
  endproperty
  property p_tick_start;
    $rose(tick_running) |-> $past(tick_start);
  endproperty
  a_primary_tick_output_ext: assert property (p_primary_tick_output_ext) else $error("primary_tick_output to ext accepted");
  a_step_len: assert property (p_step_len) else $error("step pulse length");
  a_done_rise: assert property (p_done_rise) else $error("done missing");
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  a_cnt_start: assert property (p_cnt_start) else $error("counter ran unstarted");
  a_ack_cause: assert property (p_ack_cause) else $error("unasked ack");
  a_ack_clear: assert property (p_ack_clear) else $error("ack kept pending");
  a_tick_start: assert property (p_tick_start) else $error("tick ran unstarted");
endmodule // trigger_router_sva
bind trigger_router trigger_router_sva u_sva (.clock, .rst, .route_cmd, .route_refused,
  .event_counter_setup, .counter_start, .counter_step_pulse, .counter_done_level,
  .counter_value, .counter_running, .acknowledge_command, .ack_pending, .ack_out,
  .tick_start, .tick_running);

// [tb/line_partner.sv]
`timescale 1ns/1ps
module line_partner (
  // from the block, and the far-end TTL drive
  input wire logic [7:0] ttl_out,
  input wire logic [7:0] ttl_oe,
  input wire logic [9:0] ext_out,
  input wire logic [9:0] ext_oe,
  input wire logic [7:0] ttl_far,
  // to the block
  output logic clk10_in,
  output logic [7:0] ttl_in,
  output logic [9:0] ext_in
);
  initial begin
    clk10_in = 1'b0;
    forever #50 clk10_in = ~clk10_in;
  end
  // pulled-up trigger lines; pulled-down front panel loops back
  assign ttl_in = (ttl_oe & ttl_out) | (~ttl_oe & ttl_far);
  assign ext_in = ext_oe & ext_out;
endmodule // line_partner

// [tb/tb_trigger_router.sv]
`timescale 1ns/1ps
module tb_trigger_router;
  logic clock, rst, sync_falling_edge, clk10_in, route_refused, refused;
  logic counter_start, counter_done_level, tick_start, tick_running;
  logic [7:0] ttl_in, ttl_out, ttl_oe, ttl_far;
  logic [9:0] ext_in, ext_out, ext_oe;
  logic [13:0] sense_start_command, sense_ack_needed, acknowledge_command, ack_pending;
  logic [13:0] sense_stop_command;
  logic [5:0] counter_source, tick_source;
  logic [15:0] counter_load, counter_value;
  logic [4:0] tick_exp1, tick_exp2;
  trig_pkg::route_cmd_t route_cmd;
  trig_pkg::gen_setup_t trigger_generation_setup;
  trig_pkg::ext_setup_t external_line_setup;
  trig_pkg::cnt_op_t event_counter_setup;
  trig_pkg::tick_op_t tick_timer_setup;
  int err_count, total_checks, i;
  trigger_router u_dut (.clock, .rst, .clk10_in, .ttl_in, .ecl_in(6'h00), .starx_in(13'h0000),
    .stary_in(13'h0000), .ext_in, .ttl_out, .ttl_oe, .ecl_out(), .ecl_oe(), .starx_out(),
    .starx_oe(), .stary_out(), .stary_oe(), .ext_out, .ext_oe, .route_cmd, .route_refused,
    .trigger_generation_setup, .sync_falling_edge, .external_line_setup, .sense_start_command,
    .sense_stop_command, .sense_ack_needed, .acknowledge_command,
    .trigger_sensed(), .ack_pending, .ack_out(), .event_counter_setup, .counter_source,
    .counter_load, .counter_start, .counter_stop(1'b0), .counter_step_pulse(),
    .counter_done_level, .counter_value, .counter_running(), .counter_event(),
    .tick_timer_setup, .tick_source, .tick_exp1, .tick_exp2, .tick_start, .tick_stop(1'b0),
    .primary_tick_output(), .secondary_tick_output(), .tick_running, .tick_event());
  line_partner u_far (.ttl_out, .ttl_oe, .ext_out, .ext_oe, .ttl_far, .clk10_in, .ttl_in,
    .ext_in);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one-cycle command; refusal is combinational, so sampled mid-cycle
  task automatic route(input logic c, input logic [5:0] s, input logic [5:0] d,
      input logic [3:0] m);
    route_cmd = '{c, !c, s, d, m};
    #1;
    refused = route_refused;
    cyc(1);
    route_cmd = '0;
    cyc(1);
  endtask
  task automatic srcpulse(input int n);
    ttl_far[n] = 1'b0;
    cyc(40);
    ttl_far[n] = 1'b1;
    cyc(40);
  endtask
  task automatic s_route;
    route(1, trig_pkg::TTL_BASE, trig_pkg::EXT_BASE, 4'h0);
    srcpulse(0);
    check(ext_oe[0], 1);
    ttl_far[0] = 1'b0;
    cyc(8);
    check(ext_out[0], 0);
    sync_falling_edge = 1'b1;
    route(1, trig_pkg::TTL_BASE, trig_pkg::EXT_BASE, 4'h3);
    cyc(40);
    check(ext_out[0], 1);
    route(0, trig_pkg::TTL_BASE, trig_pkg::EXT_BASE, 4'h0);
    cyc(8);
    check(ext_oe[0], 0);
    ttl_far[0] = 1'b1;
  endtask
  task automatic s_force;
    external_line_setup = '{1'b1, 4'h1, 1'b0, 1'b0, 1'b1, 1'b1};
    cyc(1);
    external_line_setup = '0;
    cyc(4);
    check({ext_oe[1], ext_out[1]}, 3);
    route(1, trig_pkg::TTL_BASE, trig_pkg::EXT_BASE + 6'h01, 4'h0);
    check(refused, 1);
    route(1, trig_pkg::PRIMARY_TICK_OUTPUT_LINE, trig_pkg::EXT_BASE + 6'h02, 4'h0);
    check(refused, 1);
    route(1, trig_pkg::SECONDARY_TICK_OUTPUT_LINE, trig_pkg::EXT_BASE + 6'h02, 4'h0);
    check(refused, 0);
  endtask
  task automatic s_count;
    counter_source = 6'h01;
    counter_load = 16'h0002;
    event_counter_setup = trig_pkg::CNT_OP_INIT;
    cyc(1);
    event_counter_setup = trig_pkg::CNT_OP_NONE;
    srcpulse(1);
    check(counter_value, 2);
    counter_start = 1'b1;
    cyc(1);
    counter_start = 1'b0;
    srcpulse(1);
    check({counter_value[14:0], counter_done_level}, 2);
    srcpulse(1);
    check(counter_done_level, 1);
    event_counter_setup = trig_pkg::CNT_OP_DISABLE;
    cyc(1);
    event_counter_setup = trig_pkg::CNT_OP_NONE;
    cyc(2);
    check(counter_done_level, 0);
  endtask
  task automatic s_ack;
    trigger_generation_setup = '{1'b1, 4'h2, 1'b1, 1'b0};
    sense_ack_needed[2] = 1'b1;
    sense_start_command[2] = 1'b1;
    cyc(1);
    trigger_generation_setup = '0;
    sense_start_command[2] = 1'b0;
    srcpulse(2);
    check(ack_pending[2], 1);
    acknowledge_command[2] = 1'b1;
    cyc(1);
    acknowledge_command[2] = 1'b0;
    cyc(2);
    check(ack_pending[2], 0);
    sense_stop_command[2] = 1'b1;
    cyc(1);
    sense_stop_command[2] = 1'b0;
    srcpulse(2);
    check(ack_pending[2], 0);
    trigger_generation_setup = '{1'b1, 4'h3, 1'b0, 1'b1};
    cyc(1);
    trigger_generation_setup = '0;
    srcpulse(3);
    check(ttl_oe[3], 1);
    acknowledge_command[3] = 1'b1;
    cyc(1);
    acknowledge_command[3] = 1'b0;
    cyc(2);
    check(ttl_oe[3], 0);
  endtask
  task automatic s_tick;
    tick_source = trig_pkg::CLK10_LINE;
    tick_timer_setup = trig_pkg::TICK_OP_INIT_MANUAL;
    cyc(1);
    tick_timer_setup = trig_pkg::TICK_OP_NONE;
    cyc(60);
    check(tick_running, 0);
    tick_start = 1'b1;
    cyc(1);
    tick_start = 1'b0;
    cyc(3);
    check(tick_running, 1);
    for (i = 0; i < 300 && tick_running === 1'b1; i++) cyc(1);
    check(tick_running, 0);
  endtask
  initial begin
    {rst, ttl_far} = 9'h1FF;
    {sync_falling_edge, counter_start, tick_start} = 3'h0;
    {sense_start_command, sense_stop_command, sense_ack_needed, acknowledge_command} = 56'h0;
    {counter_source, tick_source, counter_load, tick_exp1, tick_exp2} = 38'h2;
    {route_cmd, trigger_generation_setup, external_line_setup} = '0;
    event_counter_setup = trig_pkg::CNT_OP_NONE;
    tick_timer_setup = trig_pkg::TICK_OP_NONE;
    cyc(12);
    rst = 1'b0;
    cyc(2);
    s_route();
    s_force();
    s_count();
    s_ack();
    s_tick();
    conclude();
  end
  initial begin
    #300000;
    err_count++;
    conclude();
  end
endmodule // tb_trigger_router
